// File: inc/wdm_pkg.sv
package wdm_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] WDM_MODE_OFF   = 12'h000;
    localparam logic [11:0] WDM_STAT_OFF   = 12'h004;
    localparam logic [11:0] WDM_IRQ_OFF    = 12'h008;
    localparam logic [11:0] WDM_MASK_OFF   = 12'h00C;

    // ****************************************
    // Mode register fields
    // ****************************************
    localparam int          WDM_PER_LSB    = 0;
    localparam int          WDM_SRC_LSB    = 3;
    localparam int          WDM_FIX_LSB    = 5;
    localparam logic [7:0]  WDM_MODE_RST   = 8'h67;
    localparam logic [2:0]  WDM_FIX_VAL    = 3'h3;
    localparam logic [1:0]  WDM_SRC_SLOW   = 2'h0;
    localparam logic [1:0]  WDM_SRC_SYS    = 2'h1;
    localparam int          WDM_SLOW_BASE  = 11;
    localparam int          WDM_SYS_BASE   = 13;
    localparam int          WDM_CNT_W      = 21;

    // ****************************************
    // Interrupt status bits
    // ****************************************
    localparam int          WDM_EV_OVF     = 0;
    localparam int          WDM_EV_REWR    = 1;
    localparam int          WDM_EV_W       = 2;

    typedef struct packed {
        logic       halt_en;
        logic [1:0] src;
        logic [2:0] per;
    } wdm_cfg_t;

endpackage

// File: rtl/wdm_top.sv
// Functional notes
// (RL1) Source field: 00 slow clock, 01 system clock, 1x halts counting.
// (RL2) Slow clock period is 2^(11+n) slow ticks, largest 2^18.
// (RL3) System clock period is 2^(13+n) system cycles, smallest 2^13.
// (RL4) Halt code ignores period field; no counting and no overflow.
// (RL5) Halt or system source only works when halt permission is strapped.
// (RL6) Software writes upper bits 7..5 as 0, 1, 1.
// (RL7) Reset value selects slow clock with maximum period.
// (RL8) One write accepted after reset; second write raises internal reset.
// (RL9) Software programs source and period right after reset.
// (RL10) Writing 0111xxxx stops the watchdog.
// (RL11) Writing 01101000 selects system clock with minimum period.
// (RL12) Period code is bits 2..0, source code is bits 4..3.
// (RL13) Counter reaching selected period requests an internal reset.
module wdm_top
    import wdm_pkg::*;
#(
    parameter int CNT_W = WDM_CNT_W
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        slow_tick,
    input  wire logic        slow_osc_halt_request,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             wdt_reset_req
);

    // ****************************************
    // Bus address phase capture
    // ****************************************
    logic        wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic        acc_req;

    assign acc_req = hsel & hready & htrans[1];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= acc_req & hwrite;
            if (acc_req) begin
                wr_addr_reg <= haddr[11:0];
            end
        end
    end

    // No wait states
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Always OKAY
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    logic wr_mode;
    logic wr_stat;
    logic wr_mask;

    always_comb begin
        wr_mode = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                WDM_MODE_OFF: wr_mode = 1'b1;
                WDM_STAT_OFF: wr_stat = 1'b1;
                WDM_MASK_OFF: wr_mask = 1'b1;
                default:      wr_mode = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Mode register and one-write lock
    // ****************************************
    typedef enum logic [1:0] {
        WDM_LOCK_OPEN = 2'b00,
        WDM_LOCK_SET  = 2'b01,
        WDM_LOCK_TRIP = 2'b10
    } wdm_lock_t;

    wdm_lock_t  lock_reg;
    wdm_lock_t  lock_next;
    logic [7:0] mode_reg;
    logic       written;
    logic       first_wr;
    logic       rewrite_ev;

    assign written    = (lock_reg != WDM_LOCK_OPEN);
    assign first_wr   = wr_mode && !written; // [RL8]
    assign rewrite_ev = wr_mode && written; // [RL8]

    // Lock state: open until the first mode write
    always_comb begin
        lock_next = lock_reg;
        case (lock_reg)
            WDM_LOCK_OPEN: begin
                if (wr_mode) begin
                    lock_next = WDM_LOCK_SET;
                end
            end
            WDM_LOCK_SET: begin
                if (wr_mode) begin
                    lock_next = WDM_LOCK_TRIP; // [RL8]
                end
            end
            WDM_LOCK_TRIP: begin
                lock_next = WDM_LOCK_TRIP;
            end
            default: begin
                lock_next = WDM_LOCK_SET;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lock_reg <= WDM_LOCK_OPEN;
        end else begin
            lock_reg <= lock_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= WDM_MODE_RST; // [RL7]
        end else if (first_wr) begin
            mode_reg <= hwdata[7:0]; // [RL8]
        end
    end

    // ****************************************
    // Effective configuration
    // ****************************************
    wdm_cfg_t cfg;
    logic     run_slow;
    logic     run_sys;

    always_comb begin
        cfg.halt_en = slow_osc_halt_request;
        cfg.src     = mode_reg[WDM_SRC_LSB +: 2]; // [RL12]
        cfg.per     = mode_reg[WDM_PER_LSB +: 3]; // [RL12]
    end

    // Without permission, halt and system choices fall back to slow clock
    always_comb begin
        run_sys  = cfg.halt_en && (cfg.src == WDM_SRC_SYS); // [RL5] [RL1]
        run_slow = (cfg.src == WDM_SRC_SLOW) || !cfg.halt_en; // [RL5] [RL1]
    end

    // ****************************************
    // Watchdog counter
    // ****************************************
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] limit;
    logic             cnt_en;
    logic             ovf;

    logic [CNT_W-1:0] limit_sys;
    logic [CNT_W-1:0] limit_slow;

    // One-hot terminal values, one per source
    always_comb begin
        limit_sys  = '0;
        limit_slow = '0;
        limit_sys[WDM_SYS_BASE + int'(cfg.per)]   = 1'b1; // [RL3] [RL11]
        limit_slow[WDM_SLOW_BASE + int'(cfg.per)] = 1'b1; // [RL2]
    end

    always_comb begin
        if (run_sys) begin
            limit = limit_sys;
        end else begin
            limit = limit_slow;
        end
    end

    // Halt code leaves the counter idle
    assign cnt_en = run_sys | (run_slow & slow_tick); // [RL4]
    assign ovf    = cnt_en && (cnt_reg == limit - 1'b1); // [RL13]

    logic [CNT_W-1:0] cnt_next;

    // Accepted first write restarts the count
    always_comb begin
        cnt_next = cnt_reg;
        if (first_wr) begin
            cnt_next = '0;
        end else if (ovf) begin
            cnt_next = '0;
        end else if (cnt_en) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // ****************************************
    // Internal reset request
    // ****************************************
    logic req_next;

    assign req_next = ovf | rewrite_ev; // [RL13] [RL8]

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= req_next; // [RL13] [RL8]
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    logic [WDM_EV_W-1:0] stat_reg;
    logic [WDM_EV_W-1:0] mask_reg;
    logic [WDM_EV_W-1:0] ev;
    logic [WDM_EV_W-1:0] clr;
    logic [WDM_EV_W-1:0] pend;

    assign ev  = {rewrite_ev, ovf};
    assign clr = {WDM_EV_W{wr_stat}} & hwdata[WDM_EV_W-1:0];

    for (genvar i = 0; i < WDM_EV_W; i++) begin : g_ev
        // Set wins over write-one-to-clear
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                stat_reg[i] <= 1'b0;
            end else if (ev[i]) begin
                stat_reg[i] <= 1'b1;
            end else if (clr[i]) begin
                stat_reg[i] <= 1'b0;
            end
        end

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                mask_reg[i] <= 1'b0;
            end else if (wr_mask) begin
                mask_reg[i] <= hwdata[i];
            end
        end

        assign pend[i] = stat_reg[i] & mask_reg[i];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |pend;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] hrdata_next;

    always_comb begin
        hrdata_next = hrdata;
        if (acc_req && !hwrite) begin
            case (haddr[11:0])
                WDM_MODE_OFF: hrdata_next = {24'h00_0000, mode_reg};
                WDM_STAT_OFF: hrdata_next = {30'h0, stat_reg};
                WDM_IRQ_OFF:  hrdata_next = {31'h0, written};
                WDM_MASK_OFF: hrdata_next = {30'h0, mask_reg};
                default:      hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= hrdata_next;
        end
    end

endmodule // wdm_top

// File: tb/wdm_properties.sv
module wdm_properties (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        slow_osc_halt_request,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        wdt_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bus tracking
    // ****
    logic       rm;
    logic       w0;
    logic       wr;
    logic       dn;
    logic [7:0] md;
    wire        ap = hsel && hready && htrans[1];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {rm, w0, wr, dn, md} <= {4'h0, 8'h67};
        end else begin
            rm <= ap && !hwrite && haddr[11:0] == 12'h000;
            w0 <= ap && hwrite && haddr[11:0] == 12'h000;
            wr <= ap && hwrite;
            if (w0 && !dn) begin
                {dn, md} <= {1'b1, hwdata[7:0]};
            end
        end
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    ready_a: assert property (hreadyout)
        else $error("hreadyout low");
    okay_a: assert property (!hresp)
        else $error("hresp not okay");
    pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req [*8])
        else $error("reset request too long");
    rewrite_a: assert property (w0 && dn |-> ##[0:3] wdt_reset_req)
        else $error("second write gave no reset");
    halt_a: assert property (dn && md[4] && slow_osc_halt_request
        && !$past(w0) && !$past(w0, 2) && !$past(w0, 3) |-> !wdt_reset_req)
        else $error("halted watchdog fired");
    mode_a: assert property (rm |-> hrdata[7:0] == md)
        else $error("mode readback wrong");
    start_a: assert property ($rose(resetn) |-> !wdt_reset_req [*8])
        else $error("reset request after reset");
    irq_a: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3))
        else $error("irq fell without write");
endmodule // wdm_properties

bind wdm_top wdm_properties wdm_properties_i (.mclk, .resetn,
    .slow_osc_halt_request, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .irq, .wdt_reset_req);

// File: tb/wdm_tb.sv
module wdm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bench
    // ****
    logic        mclk, resetn, slow_tick, slow_osc_halt_request, hsel;
    logic        hwrite, hreadyout, hresp, irq, wdt_reset_req;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n, num_errors, n_compared;

    wdm_top wdm_top_i (.mclk, .resetn, .slow_tick, .slow_osc_halt_request,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .irq, .wdt_reset_req);

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) slow_tick <= ~slow_tick;

    task conclude;
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {hsel, htrans, hwrite, haddr, hsize} <= {3'h6, w, 20'h0, a, 3'h2};
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                {hsel, htrans} <= 3'h0;
                hwdata <= d;
            end
            do begin
                @(posedge mclk);
                k++;
            end while (hreadyout !== 1'b1 && k < 50);
        end
        r = hrdata;
        if (k >= 50) begin
            num_errors++;
            conclude;
        end
    endtask

    task pls;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wdt_reset_req !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            num_errors++;
            conclude;
        end
    endtask

    task rst(input logic p);
        resetn <= 1'b0;
        slow_osc_halt_request <= p;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask

    task t_sys;
        rst(1'b1);
        bus(1'b0, 12'h000, 32'h0);
        chk(r, 32'h67);
        bus(1'b1, 12'h000, 32'h68);
        bus(1'b0, 12'h000, 32'h0);
        chk(r, 32'h68);
        bus(1'b0, 12'h008, 32'h0);
        chk(r, 32'h1);
        pls;
        pls;
        chk(n, 32'd8192);
    endtask

    task t_rewr;
        bus(1'b1, 12'h000, 32'h77);
        pls;
        chk(32'(n < 4), 32'h1);
        bus(1'b0, 12'h000, 32'h0);
        chk(r, 32'h68);
        bus(1'b0, 12'h004, 32'h0);
        chk(r, 32'h3);
        bus(1'b1, 12'h00C, 32'h3);
        bus(1'b0, 12'h00C, 32'h0);
        chk(r, 32'h3);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h004, 32'h3);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task t_slow(input logic [31:0] v);
        rst(1'b0);
        bus(1'b1, 12'h000, v);
        pls;
        pls;
        chk(n, 32'd4096);
    endtask

    task t_halt;
        rst(1'b1);
        bus(1'b1, 12'h000, 32'h70);
        n = 0;
        repeat (10000) begin
            @(posedge mclk);
            if (wdt_reset_req === 1'b1) n++;
        end
        chk(n, 32'h0);
    endtask

    initial begin
        {resetn, slow_tick, slow_osc_halt_request, hsel, hwrite} = 5'h0;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        num_errors = 0;
        n_compared = 0;
        t_sys;
        t_rewr;
        t_slow(32'h60);
        t_slow(32'h70);
        t_halt;
        conclude;
    end
endmodule // wdm_tb
